/* common/epc_pkg.sv */
package epc_pkg;
    localparam int NUM_EP = 16;
    // command groups, high nibble of the code
    localparam logic [3:0] OP_STALL = 4'h4;
    localparam logic [3:0] OP_STATUS = 4'h5;
    localparam logic [3:0] OP_VALIDATE = 4'h6;
    localparam logic [3:0] OP_CLEAR = 4'h7;
    localparam logic [3:0] OP_UNSTALL = 4'h8;
    localparam logic [3:0] OP_RESULT = 4'hA;
    localparam logic [3:0] OP_CHECK = 4'hD;
    localparam logic [7:0] OP_ACK_SETUP = 8'hF4;
    localparam logic [3:0] EP_CTRL_OUT = 4'h0;
    localparam logic [3:0] EP_CTRL_IN = 4'h1;
    // status byte fields
    localparam int ST_HALT = 7;
    localparam int ST_FULL1 = 6;
    localparam int ST_FULL0 = 5;
    localparam int ST_TOGGLE = 4;
    localparam int ST_CLOB = 3;
    localparam int ST_SETUP = 2;
    localparam int ST_CPU = 1;
    // result byte fields
    localparam int RS_MISSED = 7;
    localparam int RS_TOGGLE = 6;
    localparam int RS_OK = 0;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] RESULT_RESET = 8'h00;
    typedef enum logic [3:0] {
        ERR_NONE = 4'h0, ERR_PID_CHECK = 4'h1, ERR_PID_UNKNOWN = 4'h2, ERR_UNEXPECTED = 4'h3,
        ERR_TOKEN_CRC = 4'h4, ERR_DATA_CRC = 4'h5, ERR_TIMEOUT = 4'h6, ERR_BABBLE = 4'h7,
        ERR_EARLY_END = 4'h8, ERR_NAK = 4'h9, ERR_STALL = 4'hA, ERR_OVERFLOW = 4'hB,
        ERR_EMPTY_ISO = 4'hC, ERR_STUFFING = 4'hD, ERR_SYNC = 4'hE, ERR_TOGGLE = 4'hF
    } epc_err_t;
endpackage : epc_pkg

/* hdl/epc_cmd_decode.sv */
`timescale 1ns/10ps
module epc_cmd_decode (
    // command byte
    input wire logic [7:0] cmdCode,
    // decoded command kinds
    output logic isStall,
    output logic isUnstall,
    output logic isValidate,
    output logic isClear,
    output logic isCheck,
    output logic isStatusRead,
    output logic isResultRead,
    output logic isAck,
    output logic [3:0] epSel
);
    wire [3:0] opHi = cmdCode[7:4];
    assign epSel = cmdCode[3:0]; // [R2]
    assign isStall = opHi == epc_pkg::OP_STALL; // [R1]
    assign isUnstall = opHi == epc_pkg::OP_UNSTALL; // [R1]
    assign isValidate = (opHi == epc_pkg::OP_VALIDATE) && (epSel != epc_pkg::EP_CTRL_OUT); // [R6]
    assign isClear = (opHi == epc_pkg::OP_CLEAR) && (epSel != epc_pkg::EP_CTRL_IN); // [R8]
    assign isCheck = opHi == epc_pkg::OP_CHECK; // [R10]
    assign isStatusRead = opHi == epc_pkg::OP_STATUS;
    assign isResultRead = opHi == epc_pkg::OP_RESULT; // [R18]
    assign isAck = cmdCode == epc_pkg::OP_ACK_SETUP; // [R17]
endmodule : epc_cmd_decode

/* hdl/epc_ep_state.sv */
`timescale 1ns/10ps
module epc_ep_state #(
    parameter logic IS_IN = 1'b0,
    parameter logic IS_CTRL = 1'b0,
    parameter logic DOUBLE = 1'b0
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // commands for this endpoint
    input wire logic stallCmd,
    input wire logic unstallCmd,
    input wire logic validateCmd,
    input wire logic clearCmd,
    input wire logic statusRead,
    input wire logic resultRead,
    // setup events
    input wire logic setupTok,
    input wire logic setupClobber,
    input wire logic setupWriting,
    // engine events
    input wire logic bufLoad,
    input wire logic bufSent,
    input wire logic bufSel,
    input wire logic pktDone,
    input wire logic pktOk,
    input wire logic pktToggle,
    input wire logic [3:0] pktErr,
    // state
    output logic [7:0] statusByte,
    output logic [7:0] resultByte,
    output logic nak,
    output logic reinitPulse
);
    logic halted, full0, full1, toggle, clobbered, setupPresent, cpuSel;
    logic pending, missed, lastToggle, xferOk;
    logic [3:0] errCode;
    // a restall in the setup cycle wins, so firmware can keep the halt
    wire next_halted = stallCmd | (halted & ~unstallCmd & ~(IS_CTRL & setupTok)); // [R1] [R3]
    wire reinit = halted & ~next_halted; // [R5]
    wire setF0 = (validateCmd & ~cpuSel) | (bufLoad & ~bufSel); // [R6] [R9]
    wire setF1 = DOUBLE & ((validateCmd & cpuSel) | (bufLoad & bufSel));
    wire clrF0 = (clearCmd & ~cpuSel) | (bufSent & ~bufSel); // [R8]
    wire clrF1 = (clearCmd & cpuSel) | (bufSent & bufSel);
    wire next_full0 = ~reinit & (setF0 | (full0 & ~clrF0)); // [R5]
    wire next_full1 = ~reinit & (setF1 | (full1 & ~clrF1));
    wire next_cpuSel = ~reinit & (cpuSel ^ (DOUBLE & (validateCmd | clearCmd))); // [R7]
    wire next_toggle = ~reinit & ((pktDone & pktOk) ? ~pktToggle : toggle); // [R5] [R12]
    wire next_clobbered = setupClobber | (clobbered & ~(statusRead & ~setupWriting)); // [R13]
    wire next_setup = (IS_CTRL & ~IS_IN & setupTok) | (setupPresent & ~clearCmd & ~reinit); // [R14]
    // single buffer: NAK once loaded; IN: NAK until validated
    assign nak = IS_IN ? ~(full0 | full1) : (DOUBLE ? (full0 & full1) : full0); // [R9]
    assign statusByte = {halted, full1, full0, toggle, clobbered, setupPresent, cpuSel, 1'b0}; // [R11] [R14]
    assign resultByte = {missed, lastToggle, 1'b0, errCode, xferOk}; // [R19] [R21]
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            {halted, full1, full0, toggle, clobbered, setupPresent, cpuSel} <= 7'h00;
            reinitPulse <= 1'b0;
        end else begin
            {halted, full1, full0, toggle} <= {next_halted, next_full1, next_full0, next_toggle};
            {clobbered, setupPresent, cpuSel} <= {next_clobbered, next_setup, next_cpuSel};
            reinitPulse <= reinit;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            {pending, missed, lastToggle, errCode, xferOk} <= 8'h00;
        end else if (pktDone) begin
            pending <= 1'b1; // [R18]
            missed <= pending; // [R19]
            lastToggle <= pktOk ? pktToggle : lastToggle; // [R20]
            errCode <= pktErr; // [R22]
            xferOk <= pktOk; // [R21]
        end else if (resultRead) begin
            pending <= 1'b0;
            missed <= 1'b0;
        end
    end
endmodule : epc_ep_state

/* hdl/epc_endpoint_command_control.sv */
`timescale 1ns/10ps
// Contract
// R1: codes 40h-4Fh halt the chosen endpoint, 80h-8Fh release it, no data.
// R2: low nibble picks endpoint: 0 control OUT, 1 control IN, 2-15 endpoints 1-14.
// R3: a SETUP token releases a halted control endpoint regardless of packet content.
// R4: firmware reissues halt after SETUP if the endpoint must stay halted.
// R5: leaving halt flushes the buffers and resets the toggle to DATA0.
// R6: codes 61h-6Fh mark the CPU buffer of an IN endpoint full.
// R7: on double buffering, validate and clear swap the CPU buffer.
// R8: codes 70h, 72h-7Fh empty the CPU buffer of an OUT endpoint.
// R9: a received packet fills the buffer; further packets get NAK until cleared.
// R10: codes D0h-DFh return the status byte and clear nothing.
// R11: status bit 7 halted, 6 second full, 5 first full, 0 reads zero.
// R12: status bit 4 is the toggle expected next.
// R13: bit 3 flags overwritten setup; cleared by status read once setup write ends.
// R14: bit 2 flags setup in buffer, bit 1 the CPU buffer.
// R15: firmware checks setup_clobbered_flag flag before ack or halt, abandons on one.
// R16: SETUP disables validate and clear on both control endpoints until acked.
// R17: code F4h acknowledges setup and re-enables control buffer commands.
// R18: codes A0h-AFh return the latest transaction result byte.
// R19: result bit 7 flags a newer event before the last was read; bit 5 zero.
// R20: result bit 6 is the toggle of the last good packet.
// R21: result bits 4-1 are the error code, bit 0 marks success.
// R22: error code values follow the fixed fifteen-entry failure list.
// R23: destructive status read clears the endpoint's interrupt bit.
module epc_endpoint_command_control #(
    parameter logic [15:0] EP_IN_MASK = 16'h0002,
    parameter logic [15:0] EP_DOUBLE_MASK = 16'h0000
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // command port
    input wire logic cmdValid,
    input wire logic [7:0] cmdCode,
    output logic cmdRejected,
    // read answer
    output logic [7:0] readData,
    output logic readValid,
    // setup events from the engine
    input wire logic sieSetup,
    input wire logic sieSetupDone,
    // transaction events from the engine
    input wire logic [3:0] sieEp,
    input wire logic sieLoad,
    input wire logic sieSent,
    input wire logic sieBuf,
    input wire logic siePktDone,
    input wire logic siePktOk,
    input wire logic siePktToggle,
    input wire logic [3:0] siePktErr,
    // state toward the engine
    output logic [15:0] epHalted,
    output logic [15:0] epNak,
    output logic [15:0] epReinit,
    output logic [15:0] intClear,
    output logic setupAck,
    output logic ctrlLocked
);
    logic dStall, dUnstall, dValidate, dClear, dCheck, dStatRd, dResRd, dAck;
    logic [3:0] dEp;
    logic setupWriting;
    logic [7:0] statusAll [epc_pkg::NUM_EP];
    logic [7:0] resultAll [epc_pkg::NUM_EP];
    logic [15:0] next_intClear;

    epc_cmd_decode u_decode (
        .cmdCode(cmdCode),
        .isStall(dStall),
        .isUnstall(dUnstall),
        .isValidate(dValidate),
        .isClear(dClear),
        .isCheck(dCheck),
        .isStatusRead(dStatRd),
        .isResultRead(dResRd),
        .isAck(dAck),
        .epSel(dEp)
    );

    // control buffers are frozen between setup arrival and its ack
    wire ctrlSel = (dEp == epc_pkg::EP_CTRL_OUT) || (dEp == epc_pkg::EP_CTRL_IN);
    wire ctrlBlocked = ctrlLocked && ctrlSel; // [R16]
    wire validateOk = dValidate && EP_IN_MASK[dEp] && !ctrlBlocked; // [R6] [R16]
    wire clearOk = dClear && !EP_IN_MASK[dEp] && !ctrlBlocked; // [R8] [R16]
    wire readCmd = dCheck || dStatRd || dResRd;
    wire cmdKnown = dStall || dUnstall || validateOk || clearOk || readCmd || dAck;
    assign cmdRejected = cmdValid && !cmdKnown;
    // setup_clobbered_flag only counts while neither acked nor halted
    wire setupClobber = sieSetup && ctrlLocked && !epHalted[0]; // [R13]
    wire next_locked = sieSetup || (ctrlLocked && !(cmdValid && dAck)); // [R16] [R17]
    wire next_writing = sieSetup || (setupWriting && !sieSetupDone);

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ctrlLocked <= 1'b0;
            setupWriting <= 1'b0;
            setupAck <= 1'b0;
        end else begin
            ctrlLocked <= next_locked;
            setupWriting <= next_writing;
            setupAck <= cmdValid && dAck; // [R17]
        end
    end

    genvar i;
    generate
        for (i = 0; i < epc_pkg::NUM_EP; i++) begin : g_ep
            wire hit = cmdValid && (dEp == 4'(i));
            wire evt = sieEp == 4'(i);
            localparam logic CTRL_EP = (i < 2);
            assign next_intClear[i] = hit && dStatRd; // [R23]
            epc_ep_state #(
                .IS_IN(EP_IN_MASK[i]),
                .IS_CTRL(CTRL_EP),
                .DOUBLE(EP_DOUBLE_MASK[i])
            ) u_ep (
                .clk_sys(clk_sys),
                .sys_rst(sys_rst),
                .stallCmd(hit && dStall),
                .unstallCmd(hit && dUnstall),
                .validateCmd(hit && validateOk),
                .clearCmd(hit && clearOk),
                .statusRead(hit && dStatRd),
                .resultRead(hit && dResRd),
                .setupTok(sieSetup),
                .setupClobber(setupClobber && (i == 0)),
                .setupWriting(setupWriting),
                .bufLoad(evt && sieLoad),
                .bufSent(evt && sieSent),
                .bufSel(sieBuf),
                .pktDone(evt && siePktDone),
                .pktOk(siePktOk),
                .pktToggle(siePktToggle),
                .pktErr(siePktErr),
                .statusByte(statusAll[i]),
                .resultByte(resultAll[i]),
                .nak(epNak[i]),
                .reinitPulse(epReinit[i])
            );
            assign epHalted[i] = statusAll[i][epc_pkg::ST_HALT];
        end
    endgenerate

    // answer is latched at the command edge and stands until the next read
    wire [7:0] next_readData = dResRd ? resultAll[dEp] : statusAll[dEp]; // [R10] [R18]
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            readData <= epc_pkg::STATUS_RESET;
            readValid <= 1'b0;
            intClear <= 16'h0000;
        end else begin
            readData <= (cmdValid && readCmd) ? next_readData : readData;
            readValid <= cmdValid && readCmd;
            intClear <= next_intClear;
        end
    end

    // checking helpers
    logic [3:0] cmdEpQ;
    logic cpuSelQ, readWasResult;
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            cmdEpQ <= 4'h0;
            cpuSelQ <= 1'b0;
            readWasResult <= 1'b0;
        end else begin
            cmdEpQ <= dEp;
            cpuSelQ <= statusAll[dEp][epc_pkg::ST_CPU];
            readWasResult <= dResRd;
        end
    end
    wire selFull = statusAll[cmdEpQ][epc_pkg::ST_FULL0] || statusAll[cmdEpQ][epc_pkg::ST_FULL1];

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    stall_sets_a: assert property ( // [R1]
        cmdValid && dStall |=> epHalted[cmdEpQ])
        else $error("halt command did not halt endpoint");
    unstall_clears_a: assert property ( // [R1]
        cmdValid && dUnstall |=> !epHalted[cmdEpQ])
        else $error("release command left endpoint halted");
    setup_release_a: assert property ( // [R3]
        sieSetup && !(cmdValid && dStall) |=> !epHalted[0] && !epHalted[1])
        else $error("setup did not release control endpoints");
    reinit_flush_a: assert property ( // [R5]
        $fell(epHalted[0]) |-> epReinit[0] && !statusAll[0][epc_pkg::ST_TOGGLE]
            && !statusAll[0][epc_pkg::ST_FULL0] && !statusAll[0][epc_pkg::ST_FULL1])
        else $error("release did not flush endpoint");
    validate_full_a: assert property ( // [R6]
        cmdValid && validateOk && !dStall && !sieSetup |=> selFull)
        else $error("validate left buffer empty");
    double_swap_a: assert property ( // [R7]
        cmdValid && (validateOk || clearOk) && EP_DOUBLE_MASK[dEp] && !epHalted[dEp]
            |=> statusAll[cmdEpQ][epc_pkg::ST_CPU] != cpuSelQ)
        else $error("double buffer did not swap");
    out_nak_a: assert property ( // [R9]
        !EP_IN_MASK[4] && !EP_DOUBLE_MASK[4] && statusAll[4][epc_pkg::ST_FULL0] |-> epNak[4])
        else $error("full OUT buffer not refused");
    check_keeps_a: assert property ( // [R10]
        cmdValid && dCheck |=> intClear == 16'h0000 && readValid)
        else $error("check disturbed interrupt state");
    read_answer_a: assert property ( // [R18]
        cmdValid && (dCheck || dResRd) |=> readValid)
        else $error("read answer missing");
    reserved_zero_a: assert property ( // [R11]
        readValid && !readWasResult |-> !readData[0])
        else $error("reserved status bit set");
    result_rsv_a: assert property ( // [R19]
        readValid && readWasResult |-> !readData[5])
        else $error("reserved result bit set");
    setup_lock_a: assert property ( // [R16]
        sieSetup |=> ctrlLocked && (!(cmdValid && dValidate && ctrlSel) || cmdRejected))
        else $error("setup did not lock control buffers");
    locked_refuse_a: assert property ( // [R16]
        ctrlLocked && cmdValid && (dValidate || dClear) && ctrlSel |-> cmdRejected)
        else $error("locked control buffer command accepted");
    ack_unlock_a: assert property ( // [R17]
        cmdValid && dAck && !sieSetup |=> !ctrlLocked && setupAck ##1 setupAck == $past(cmdValid && dAck))
        else $error("ack did not unlock");
    clobber_set_a: assert property ( // [R13]
        sieSetup && ctrlLocked && !epHalted[0] |=> statusAll[0][epc_pkg::ST_CLOB])
        else $error("setup setup_clobbered_flag not flagged");
    clobber_hold_a: assert property ( // [R13]
        statusAll[0][epc_pkg::ST_CLOB] && setupWriting && !sieSetupDone
            |=> statusAll[0][epc_pkg::ST_CLOB])
        else $error("setup_clobbered_flag flag cleared during setup write");
    int_clear_a: assert property ( // [R23]
        cmdValid && dStatRd |=> intClear[cmdEpQ])
        else $error("status read did not clear interrupt");

    // answer path: a pulse only after a read, carrying the copy of that moment, and a check that clears no flag
    read_pulse_a: assert property ( // [R10] [R18]
        readValid |-> $past(cmdValid && readCmd))
        else $error("read answer without read command");
    status_copy_a: assert property ( // [R10]
        cmdValid && dCheck |=> readData == $past(statusAll[dEp]))
        else $error("check answer is not the status copy");
    result_copy_a: assert property ( // [R18]
        cmdValid && dResRd |=> readData == $past(resultAll[dEp]))
        else $error("result answer is not the result byte");
    check_hold_a: assert property ( // [R10]
        cmdValid && dCheck && statusAll[0][epc_pkg::ST_CLOB] |=> statusAll[0][epc_pkg::ST_CLOB])
        else $error("check cleared setup_clobbered_flag flag");

    // engine results, excluding cycles where a release flushes the toggle
    good_toggle_a: assert property ( // [R12]
        siePktDone && siePktOk && !(cmdValid && dUnstall) && !sieSetup
            |=> statusAll[$past(sieEp)][epc_pkg::ST_TOGGLE] != $past(siePktToggle))
        else $error("expected toggle not advanced");
    result_toggle_a: assert property ( // [R20]
        siePktDone && siePktOk |=> resultAll[$past(sieEp)][epc_pkg::RS_TOGGLE] == $past(siePktToggle))
        else $error("last toggle not recorded");
    result_code_a: assert property ( // [R21] [R22]
        siePktDone |=> resultAll[$past(sieEp)][4:1] == $past(siePktErr)
            && resultAll[$past(sieEp)][epc_pkg::RS_OK] == $past(siePktOk))
        else $error("result code not recorded");

    // setup gating, setup_clobbered_flag flag and the release pulse
    lock_hold_a: assert property ( // [R16]
        ctrlLocked && !(cmdValid && dAck) |=> ctrlLocked)
        else $error("control lock dropped without ack");
    setup_mark_a: assert property ( // [R14]
        sieSetup |=> statusAll[0][epc_pkg::ST_SETUP])
        else $error("setup packet not marked");
    clobber_clear_a: assert property ( // [R13]
        cmdValid && dStatRd && dEp == epc_pkg::EP_CTRL_OUT && !setupWriting && !setupClobber
            |=> !statusAll[0][epc_pkg::ST_CLOB])
        else $error("setup_clobbered_flag flag not cleared by read");
    reinit_pulse_a: assert property ( // [R5]
        epReinit[0] |-> $fell(epHalted[0]))
        else $error("reinit without release");

    // direction checks on buffer commands, and clear emptying the buffer
    in_only_a: assert property ( // [R6]
        cmdValid && dValidate && !EP_IN_MASK[dEp] |-> cmdRejected)
        else $error("validate on OUT endpoint accepted");
    out_only_a: assert property ( // [R8]
        cmdValid && dClear && EP_IN_MASK[dEp] |-> cmdRejected)
        else $error("clear on IN endpoint accepted");
    clear_empty_a: assert property ( // [R8]
        cmdValid && clearOk && !EP_DOUBLE_MASK[dEp] && !sieLoad |=> !statusAll[cmdEpQ][epc_pkg::ST_FULL0])
        else $error("clear left buffer full");

    stall_setup_c: cover property (cmdValid && dStall ##[1:20] sieSetup);
    double_use_c: cover property (cmdValid && clearOk && EP_DOUBLE_MASK[dEp] ##[1:20] cmdValid && clearOk);
    clobber_c: cover property (setupClobber ##[1:30] cmdValid && dStatRd);
    result_read_c: cover property (siePktDone && !siePktOk ##[1:20] cmdValid && dResRd);
endmodule : epc_endpoint_command_control

/* verif/epc_sie_model.sv */
`timescale 1ns/10ps
module epc_sie_model (
    // clock
    input wire logic clk_sys,
    // events toward the block
    output logic sieSetup,
    output logic sieSetupDone,
    output logic [3:0] sieEp,
    output logic sieLoad,
    output logic sieSent,
    output logic sieBuf,
    output logic siePktDone,
    output logic siePktOk,
    output logic siePktToggle,
    output logic [3:0] siePktErr
);
    initial begin
        {sieSetup, sieSetupDone, sieLoad, sieSent, siePktDone} = 5'h00;
        {sieEp, sieBuf, siePktOk, siePktToggle, siePktErr} = 11'h000;
    end
    // kind 0 setup, 1 setup written, 2 load, 3 sent, 4 transaction end
    task automatic ev(input int kind, input logic [3:0] ep, input logic b, input logic ok,
            input logic tog, input logic [3:0] err);
        @(posedge clk_sys);
        sieSetup <= (kind == 0);
        sieSetupDone <= (kind == 1);
        sieLoad <= (kind == 2);
        sieSent <= (kind == 3);
        siePktDone <= (kind == 4);
        {sieEp, sieBuf, siePktOk, siePktToggle, siePktErr} <= {ep, b, ok, tog, err};
        @(posedge clk_sys);
        {sieSetup, sieSetupDone, sieLoad, sieSent, siePktDone} <= 5'h00;
        // qualifiers go stale on purpose, so nothing may use them outside a pulse
        {sieEp, sieBuf, siePktOk, siePktToggle, siePktErr} <= ~{ep, b, ok, tog, err};
        #1;
    endtask : ev
endmodule : epc_sie_model

/* verif/testbench.sv */
`timescale 1ns/10ps
module testbench;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic cmdValid = 1'b0;
    logic [7:0] cmdCode = 8'h00;
    logic cmdRejected, readValid, sieSetup, sieSetupDone, sieLoad, sieSent, sieBuf;
    logic siePktDone, siePktOk, siePktToggle, setupAck, ctrlLocked, rej;
    logic [7:0] readData;
    logic [3:0] sieEp, siePktErr;
    logic [15:0] epHalted, epNak, epReinit, intClear;
    logic [7:0] badCodes [4] = '{8'h60, 8'h71, 8'h64, 8'h72};
    int n_errors = 0;
    int tests_run = 0;
    always #20 clk_sys = ~clk_sys;
    // ep1 and ep2 are IN, ep3 is double-buffered OUT
    epc_endpoint_command_control #(.EP_IN_MASK(16'h0006), .EP_DOUBLE_MASK(16'h0008)) i_dut (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .cmdValid(cmdValid), .cmdCode(cmdCode),
        .cmdRejected(cmdRejected), .readData(readData), .readValid(readValid), .sieSetup(sieSetup),
        .sieSetupDone(sieSetupDone), .sieEp(sieEp), .sieLoad(sieLoad), .sieSent(sieSent), .sieBuf(sieBuf),
        .siePktDone(siePktDone), .siePktOk(siePktOk), .siePktToggle(siePktToggle), .siePktErr(siePktErr),
        .epHalted(epHalted), .epNak(epNak), .epReinit(epReinit), .intClear(intClear),
        .setupAck(setupAck), .ctrlLocked(ctrlLocked));
    epc_sie_model i_sie (
        .clk_sys(clk_sys), .sieSetup(sieSetup), .sieSetupDone(sieSetupDone), .sieEp(sieEp),
        .sieLoad(sieLoad), .sieSent(sieSent), .sieBuf(sieBuf), .siePktDone(siePktDone),
        .siePktOk(siePktOk), .siePktToggle(siePktToggle), .siePktErr(siePktErr));
    task automatic final_report;
        $display("mismatches %0d, comparisons %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : final_report
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_byte
    task automatic chk_bit(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: flag got %h expected %h", $time, got, exp);
        end
    endtask : chk_bit
    // one command byte; rejection is sampled in the command cycle, other outputs just after the answering edge
    task automatic issue(input logic [7:0] code);
        @(posedge clk_sys);
        cmdValid <= 1'b1;
        cmdCode <= code;
        #1 rej = cmdRejected;
        @(posedge clk_sys);
        cmdValid <= 1'b0;
        #1;
    endtask : issue
    task automatic status(input logic [3:0] ep, input logic [7:0] exp);
        issue({epc_pkg::OP_CHECK, ep});
        chk_bit(readValid, 1'b1);
        chk_byte(readData, exp);
    endtask : status
    task automatic result(input logic [3:0] ep, input logic [7:0] exp);
        issue({epc_pkg::OP_RESULT, ep});
        chk_bit(readValid, 1'b1);
        chk_byte(readData, exp);
    endtask : result
    task automatic t_in_path;
        issue(8'h62);
        chk_bit(rej, 1'b0);
        status(4'h2, 8'h20);
        i_sie.ev(4, 4'h2, 1'b0, 1'b1, 1'b0, 4'h0);
        status(4'h2, 8'h30);
        result(4'h2, 8'h01);
        i_sie.ev(3, 4'h2, 1'b0, 1'b0, 1'b0, 4'h0);
        issue(8'h62);
        issue(8'h42);
        chk_bit(epHalted[2], 1'b1);
        status(4'h2, 8'hB0);
        issue(8'h82);
        chk_bit(epReinit[2], 1'b1);
        chk_bit(epHalted[2], 1'b0);
        status(4'h2, 8'h00);
    endtask : t_in_path
    task automatic t_out_path;
        i_sie.ev(2, 4'h3, 1'b0, 1'b0, 1'b0, 4'h0);
        chk_bit(epNak[3], 1'b0);
        i_sie.ev(2, 4'h3, 1'b1, 1'b0, 1'b0, 4'h0);
        chk_bit(epNak[3], 1'b1);
        status(4'h3, 8'h60);
        issue(8'h73);
        status(4'h3, 8'h42);
        issue(8'h73);
        status(4'h3, 8'h00);
        i_sie.ev(2, 4'h4, 1'b0, 1'b0, 1'b0, 4'h0);
        chk_bit(epNak[4], 1'b1);
        issue(8'h74);
        chk_bit(epNak[4], 1'b0);
        i_sie.ev(4, 4'h4, 1'b0, 1'b1, 1'b1, 4'h0);
        result(4'h4, 8'h41);
        foreach (badCodes[i]) begin
            issue(badCodes[i]);
            chk_bit(rej, 1'b1);
        end
    endtask : t_out_path
    task automatic t_errors;
        for (int e = 1; e < 16; e++) begin
            i_sie.ev(4, 4'h3, 1'b0, 1'b0, 1'b0, e[3:0]);
            result(4'h3, {3'b000, e[3:0], 1'b0});
        end
        i_sie.ev(4, 4'h3, 1'b0, 1'b0, 1'b0, 4'h9);
        i_sie.ev(4, 4'h3, 1'b0, 1'b0, 1'b0, 4'h9);
        result(4'h3, 8'h92);
        result(4'h3, 8'h12);
    endtask : t_errors
    task automatic t_setup;
        issue(8'h40);
        issue(8'h41);
        i_sie.ev(0, 4'h0, 1'b0, 1'b0, 1'b0, 4'h0);
        chk_bit(epHalted[0], 1'b0);
        chk_bit(epHalted[1], 1'b0);
        chk_bit(ctrlLocked, 1'b1);
        status(4'h0, 8'h04);
        issue(8'h70);
        chk_bit(rej, 1'b1);
        issue(8'h61);
        chk_bit(rej, 1'b1);
        i_sie.ev(0, 4'h0, 1'b0, 1'b0, 1'b0, 4'h0);
        status(4'h0, 8'h0C);
        issue(8'h50);
        chk_bit(intClear[0], 1'b1);
        chk_byte(readData, 8'h0C);
        status(4'h0, 8'h0C);
        i_sie.ev(1, 4'h0, 1'b0, 1'b0, 1'b0, 4'h0);
        issue(8'h50);
        status(4'h0, 8'h04);
        issue(epc_pkg::OP_ACK_SETUP);
        chk_bit(setupAck, 1'b1);
        chk_bit(ctrlLocked, 1'b0);
        issue(8'h70);
        chk_bit(rej, 1'b0);
        status(4'h0, 8'h00);
        issue(8'h40);
        chk_bit(epHalted[0], 1'b1);
    endtask : t_setup
    initial begin
        repeat (4) @(posedge clk_sys);
        sys_rst <= 1'b0;
        status(4'h5, epc_pkg::STATUS_RESET);
        result(4'h5, epc_pkg::RESULT_RESET);
        t_in_path();
        t_out_path();
        t_errors();
        t_setup();
        final_report();
    end
    // hang guard, far beyond the roughly 160 cycles the run needs
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_errors++;
        final_report();
    end
endmodule : testbench
